// ### rtl/tspm_mux.sv
`timescale 1ns/1ps
module tspm_mux
    import tspm_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RESET,
    // Configuration
    input wire logic [7:0] TIMER2_REMAP_OPTION,
    input wire logic [3:0] TIMER2_CAPTURE_COMPARE_ENABLE,
    input wire logic [15:0] PORT_A_LOW_CONFIG,
    input wire logic [3:0] PORT_B_HIGH_CONFIG,
    input wire logic [1:0] SERIAL1_MODE_SELECT,
    input wire logic [7:0] SERIAL1_UART_CONFIG,
    input wire logic [7:0] SERIAL1_SPI_CONFIG,
    input wire logic [1:0] SERIAL2_MODE_SELECT,
    input wire logic [7:0] SERIAL2_SPI_CONFIG,
    input wire logic TRACE_ENABLE,
    // Peripheral outputs
    input wire logic [3:0] TIMER2_CHANNEL_OUT,
    input wire logic SERIAL1_REQUEST_TO_SEND_N,
    input wire logic SERIAL2_MASTER_OUT_TX,
    input wire logic SERIAL2_MASTER_IN_TX,
    input wire logic SERIAL2_SPI_CLOCK_TX,
    input wire logic SERIAL2_TWOWIRE_DATA_TX,
    input wire logic SERIAL2_TWOWIRE_CLOCK_TX,
    input wire logic CPU_TRACE_CLOCK,
    // Plain port registers, bit 0..3 = A0..A3, bit 4 = B4
    input wire logic [4:0] GPIO_OUT,
    // Pins: input, output, output enable (low drives)
    input wire logic [4:0] PIN_IN,
    output logic [4:0] PIN_OUT,
    output logic [4:0] PIN_OE_N,
    // Inputs to peripherals
    output logic [4:0] GPIO_IN,
    output logic [3:0] TIMER2_CHANNEL_IN,
    output logic SERIAL1_SLAVE_SELECT_N,
    output logic SERIAL2_MASTER_OUT_RX,
    output logic SERIAL2_MASTER_IN_RX,
    output logic SERIAL2_SPI_CLOCK_RX,
    output logic SERIAL2_SLAVE_SELECT_N,
    output logic SERIAL2_TWOWIRE_DATA_RX,
    output logic SERIAL2_TWOWIRE_CLOCK_RX
);
    logic [4:0] pin_sync;
    logic [4:0] pin_out_ff;
    logic [4:0] pin_oe_n_ff;
    logic [4:0] gpio_in_ff;
    logic [3:0] cap_ff;
    logic [6:0] sc_in_ff;
    logic [4:0] nxt_pin_out;
    logic [4:0] nxt_pin_oe_n;
    logic [3:0] nxt_cap;
    logic [6:0] nxt_sc_in;

    // Pad inputs cross from outside the clock domain
    tspm_sync #(.WIDTH(5)) u_sync (
        .clk(CLK_SYS),
        .rst(RESET),
        .d(PIN_IN),
        .q(pin_sync)
    );

    // Field extraction [R07]
    wire [3:0] cfg_pa0 = PORT_A_LOW_CONFIG[TSPM_CFG_PA0_LSB +: TSPM_CFG_W];
    wire [3:0] cfg_pa1 = PORT_A_LOW_CONFIG[TSPM_CFG_PA1_LSB +: TSPM_CFG_W];
    wire [3:0] cfg_pa2 = PORT_A_LOW_CONFIG[TSPM_CFG_PA2_LSB +: TSPM_CFG_W];
    wire [3:0] cfg_pa3 = PORT_A_LOW_CONFIG[TSPM_CFG_PA3_LSB +: TSPM_CFG_W];
    wire [3:0] cfg_pb4 = PORT_B_HIGH_CONFIG[TSPM_CFG_PB4_LSB +: TSPM_CFG_W];
    wire [19:0] cfg_all = {cfg_pb4, cfg_pa3, cfg_pa2, cfg_pa1, cfg_pa0};

    // Alternate-output test, used for every pin
    function automatic logic is_alt(input logic [3:0] cfg);
        is_alt = (cfg == TSPM_CFG_ALT_OUT) || (cfg == TSPM_CFG_ALT_OD);
    endfunction : is_alt

    // Open-drain test, alternate or plain
    function automatic logic is_od(input logic [3:0] cfg);
        is_od = (cfg == TSPM_CFG_ALT_OD) || (cfg == TSPM_CFG_OUT_OD);
    endfunction : is_od

    // Plain output test (push-pull or open-drain GPIO)
    function automatic logic is_gpo(input logic [3:0] cfg);
        is_gpo = (cfg == TSPM_CFG_OUT) || (cfg == TSPM_CFG_OUT_OD);
    endfunction : is_gpo

    // Remap bits
    wire rmp1 = TIMER2_REMAP_OPTION[TSPM_REMAP_CH1_BIT];
    wire rmp2 = TIMER2_REMAP_OPTION[TSPM_REMAP_CH2_BIT];
    wire rmp3 = TIMER2_REMAP_OPTION[TSPM_REMAP_CH3_BIT];
    wire rmp4 = TIMER2_REMAP_OPTION[TSPM_REMAP_CH4_BIT];
    wire [3:0] ten = TIMER2_CAPTURE_COMPARE_ENABLE; // Bit n-1 enables channel n

    // Serial mode decode
    wire s1_uart = SERIAL1_MODE_SELECT == TSPM_MODE_UART;
    wire s1_spi = SERIAL1_MODE_SELECT == TSPM_MODE_SPI;
    wire s1_slave = s1_spi && !SERIAL1_SPI_CONFIG[TSPM_SPI_MASTER_BIT]; // [R12]
    wire s1_rts = s1_uart && SERIAL1_UART_CONFIG[TSPM_UART_RTS_BIT]; // [R11]
    wire s2_spi = SERIAL2_MODE_SELECT == TSPM_MODE_SPI;
    wire s2_twi = SERIAL2_MODE_SELECT == TSPM_MODE_TWI;
    wire s2_master = s2_spi && SERIAL2_SPI_CONFIG[TSPM_SPI_MASTER_BIT]; // [R08]
    wire s2_slave = s2_spi && !SERIAL2_SPI_CONFIG[TSPM_SPI_MASTER_BIT]; // [R08]

    // Timer drive per pin: channel routed here, enabled, alternate selected
    wire t_pa0 = !rmp1 && ten[0] && is_alt(cfg_pa0); // [R02] [R05]
    wire t_pa1 = !rmp3 && ten[2] && is_alt(cfg_pa1); // [R03] [R05]
    wire t_pa2 = !rmp4 && ten[3] && is_alt(cfg_pa2); // [R01] [R05]
    wire t_pa3 = !rmp2 && ten[1] && is_alt(cfg_pa3); // [R04] [R05]
    wire t_pb4 = rmp4 && ten[3] && is_alt(cfg_pb4); // [R01] [R05]

    // Timer yields the pin when its output is off or moved away
    wire y_pa0 = !ten[0] || rmp1; // [R06]
    wire y_pa1 = !ten[2] || rmp3; // [R06]
    wire y_pa2 = !ten[3] || rmp4; // [R06]
    wire y_pa3 = !ten[1] || rmp2; // [R06] [R13]
    wire y_pb4 = !ten[3] || !rmp4; // [R06]

    // Shared-function drive requests (alternate selected and timer yields)
    wire f_pa0 = y_pa0 && is_alt(cfg_pa0) && s2_master; // [R08]
    wire f_pa1 = y_pa1 && is_alt(cfg_pa1) && (s2_slave || s2_twi); // [R08] [R10]
    wire f_pa2 = y_pa2 && is_alt(cfg_pa2) && (s2_master || s2_twi); // [R08] [R10]
    wire f_pa3 = y_pa3 && is_alt(cfg_pa3) && TRACE_ENABLE; // [R13]
    wire f_pb4 = y_pb4 && is_alt(cfg_pb4) && s1_rts; // [R11]

    // Function data per pin
    wire d_pa1 = s2_twi ? SERIAL2_TWOWIRE_DATA_TX : SERIAL2_MASTER_IN_TX; // [R10]
    wire d_pa2 = s2_twi ? SERIAL2_TWOWIRE_CLOCK_TX : SERIAL2_SPI_CLOCK_TX; // [R10]

    // Pin output selection; timer first, then shared function, then GPIO
    always_comb begin
        nxt_pin_out = GPIO_OUT;
        nxt_pin_oe_n = TSPM_OE_N_RST;
        for (int i = 0; i < 5; i++) begin
            if (is_gpo(cfg_all[4*i +: 4])) begin
                nxt_pin_oe_n[i] = 1'b0; // [R14]
            end
        end
        if (t_pa0) begin
            nxt_pin_out[0] = TIMER2_CHANNEL_OUT[0];
            nxt_pin_oe_n[0] = 1'b0;
        end else if (f_pa0) begin
            nxt_pin_out[0] = SERIAL2_MASTER_OUT_TX;
            nxt_pin_oe_n[0] = 1'b0;
        end
        if (t_pa1) begin
            nxt_pin_out[1] = TIMER2_CHANNEL_OUT[2];
            nxt_pin_oe_n[1] = 1'b0;
        end else if (f_pa1) begin
            nxt_pin_out[1] = d_pa1;
            nxt_pin_oe_n[1] = 1'b0;
        end
        if (t_pa2) begin
            nxt_pin_out[2] = TIMER2_CHANNEL_OUT[3];
            nxt_pin_oe_n[2] = 1'b0;
        end else if (f_pa2) begin
            nxt_pin_out[2] = d_pa2;
            nxt_pin_oe_n[2] = 1'b0;
        end
        if (t_pa3) begin
            nxt_pin_out[3] = TIMER2_CHANNEL_OUT[1];
            nxt_pin_oe_n[3] = 1'b0;
        end else if (f_pa3) begin
            nxt_pin_out[3] = CPU_TRACE_CLOCK;
            nxt_pin_oe_n[3] = 1'b0;
        end
        if (t_pb4) begin
            nxt_pin_out[4] = TIMER2_CHANNEL_OUT[3];
            nxt_pin_oe_n[4] = 1'b0;
        end else if (f_pb4) begin
            nxt_pin_out[4] = SERIAL1_REQUEST_TO_SEND_N;
            nxt_pin_oe_n[4] = 1'b0;
        end
        // Open-drain: drive only a low, release for a high [R10]
        for (int i = 0; i < 5; i++) begin
            if (is_od(cfg_all[4*i +: 4]) && !nxt_pin_oe_n[i]) begin
                nxt_pin_oe_n[i] = nxt_pin_out[i];
                nxt_pin_out[i] = 1'b0;
            end
        end
    end

    // Capture inputs follow remap only, not the output selection [R15]
    assign nxt_cap[0] = rmp1 ? 1'b0 : pin_sync[0]; // [R02]
    assign nxt_cap[1] = rmp2 ? 1'b0 : pin_sync[3]; // [R04]
    assign nxt_cap[2] = rmp3 ? 1'b0 : pin_sync[1]; // [R03]
    assign nxt_cap[3] = rmp4 ? pin_sync[4] : pin_sync[2]; // [R01]

    // Serial inputs; idle level when the role does not use the pin
    assign nxt_sc_in[0] = s1_slave ? pin_sync[4] : 1'b1; // [R12]
    assign nxt_sc_in[1] = s2_slave ? pin_sync[0] : 1'b0; // [R08]
    assign nxt_sc_in[2] = s2_master ? pin_sync[1] : 1'b0; // [R08]
    assign nxt_sc_in[3] = s2_slave ? pin_sync[2] : 1'b0; // [R09]
    assign nxt_sc_in[4] = s2_slave ? pin_sync[3] : 1'b1; // [R09]
    assign nxt_sc_in[5] = s2_twi ? pin_sync[1] : 1'b1; // [R10]
    assign nxt_sc_in[6] = s2_twi ? pin_sync[2] : 1'b1; // [R10]

    // All outputs registered; pins released during reset
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            pin_out_ff <= TSPM_PIN_RST;
            pin_oe_n_ff <= TSPM_OE_N_RST;
            gpio_in_ff <= TSPM_PIN_RST;
            cap_ff <= TSPM_CAP_RST;
            sc_in_ff <= TSPM_SC_IN_RST;
        end else begin
            pin_out_ff <= nxt_pin_out;
            pin_oe_n_ff <= nxt_pin_oe_n;
            gpio_in_ff <= pin_sync; // [R14]
            cap_ff <= nxt_cap;
            sc_in_ff <= nxt_sc_in;
        end
    end

    assign PIN_OUT = pin_out_ff;
    assign PIN_OE_N = pin_oe_n_ff;
    assign GPIO_IN = gpio_in_ff;
    assign TIMER2_CHANNEL_IN = cap_ff;
    assign SERIAL1_SLAVE_SELECT_N = sc_in_ff[0];
    assign SERIAL2_MASTER_OUT_RX = sc_in_ff[1];
    assign SERIAL2_MASTER_IN_RX = sc_in_ff[2];
    assign SERIAL2_SPI_CLOCK_RX = sc_in_ff[3];
    assign SERIAL2_SLAVE_SELECT_N = sc_in_ff[4];
    assign SERIAL2_TWOWIRE_DATA_RX = sc_in_ff[5];
    assign SERIAL2_TWOWIRE_CLOCK_RX = sc_in_ff[6];
endmodule : tspm_mux

// ### rtl/tspm_pkg.sv
// Overview of operation
// [R01] Channel four on port B4 when remap bit 7 set
// [R02] Channel one on port A0 while remap bit 4 clear
// [R03] Channel three on port A1 while remap bit 6 clear
// [R04] Channel two on port A3 while remap bit 5 clear
// [R05] Timer output needs enable and alternate output
// [R06] Serial or trace output only when timer yields
// [R07] Config fields: A0-A3 in nibbles, B4 low nibble
// [R08] Serial two SPI role follows config bit 4
// [R09] Serial two slave: select A3, clock A2
// [R10] Serial two two-wire: data A1, clock A2, open-drain
// [R11] Serial one request-to-send on B4, UART, bit 5
// [R12] Serial one slave select from B4 in slave role
// [R13] Trace clock on A3 only when enabled and timer yields
// [R14] Non-alternate, non-analog pin acts as plain GPIO
// [R15] Timer capture samples selected pin always
package tspm_pkg;
    // Remap option bit positions
    localparam int TSPM_REMAP_CH1_BIT = 4;
    localparam int TSPM_REMAP_CH2_BIT = 5;
    localparam int TSPM_REMAP_CH3_BIT = 6;
    localparam int TSPM_REMAP_CH4_BIT = 7;
    // Configuration field positions (low bit of each nibble)
    localparam int TSPM_CFG_PA0_LSB = 0;
    localparam int TSPM_CFG_PA1_LSB = 4;
    localparam int TSPM_CFG_PA2_LSB = 8;
    localparam int TSPM_CFG_PA3_LSB = 12;
    localparam int TSPM_CFG_PB4_LSB = 0;
    localparam int TSPM_CFG_W = 4;
    // Pin function codes of a configuration field
    localparam logic [3:0] TSPM_CFG_ANALOG = 4'h0;
    localparam logic [3:0] TSPM_CFG_OUT = 4'h1;
    localparam logic [3:0] TSPM_CFG_OUT_OD = 4'h5;
    localparam logic [3:0] TSPM_CFG_ALT_OUT = 4'h9;
    localparam logic [3:0] TSPM_CFG_ALT_OD = 4'hD;
    // Serial config bit positions
    localparam int TSPM_SPI_MASTER_BIT = 4;
    localparam int TSPM_UART_RTS_BIT = 5;
    // Serial mode codes
    localparam logic [1:0] TSPM_MODE_OFF = 2'h0;
    localparam logic [1:0] TSPM_MODE_UART = 2'h1;
    localparam logic [1:0] TSPM_MODE_SPI = 2'h2;
    localparam logic [1:0] TSPM_MODE_TWI = 2'h3;
    // Reset values
    localparam logic [4:0] TSPM_PIN_RST = 5'h00;
    localparam logic [4:0] TSPM_OE_N_RST = 5'h1F;
    localparam logic [3:0] TSPM_CAP_RST = 4'h0;
    // Serial inputs idle: both selects and both two-wire lines high
    localparam logic [6:0] TSPM_SC_IN_RST = 7'h71;
endpackage : tspm_pkg

// ### rtl/tspm_sync.sv
`timescale 1ns/1ps
// Three-stage pin synchroniser; a change counts once stages two and three agree
module tspm_sync #(
    parameter int WIDTH = 5
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] q_ff;
    logic [WIDTH-1:0] nxt_q;

    // Hold the old value while the two late stages disagree
    assign nxt_q = (s2_ff == s3_ff) ? s3_ff : q_ff;
    assign q = q_ff;

    // Stage one feeds only stage two
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            q_ff <= '0;
        end else begin
            s1_ff <= d;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            q_ff <= nxt_q;
        end
    end
endmodule : tspm_sync

// ### verif/tspm_board.sv
`timescale 1ns/1ps
// Board side of the five pads; a released pad is held high by a board pull-up
module tspm_board (
    input wire logic [4:0] pin_out,
    input wire logic [4:0] pin_oe_n,
    input wire logic [4:0] ext_en,
    input wire logic [4:0] ext_val,
    output logic [4:0] pin_in
);
    // Pad wins while driving; contention with the board is not modelled
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val) | (pin_oe_n & ~ext_en);
endmodule : tspm_board

// ### verif/tspm_mux_checker.sv
`timescale 1ns/1ps
module tspm_mux_checker
    import tspm_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic [7:0] TIMER2_REMAP_OPTION,
    input wire logic [3:0] TIMER2_CAPTURE_COMPARE_ENABLE,
    input wire logic [15:0] PORT_A_LOW_CONFIG,
    input wire logic [3:0] PORT_B_HIGH_CONFIG,
    input wire logic [1:0] SERIAL1_MODE_SELECT,
    input wire logic [7:0] SERIAL1_UART_CONFIG,
    input wire logic [1:0] SERIAL2_MODE_SELECT,
    input wire logic [7:0] SERIAL2_SPI_CONFIG,
    input wire logic TRACE_ENABLE,
    input wire logic [3:0] TIMER2_CHANNEL_OUT,
    input wire logic SERIAL1_REQUEST_TO_SEND_N,
    input wire logic SERIAL2_MASTER_OUT_TX,
    input wire logic SERIAL2_TWOWIRE_DATA_TX,
    input wire logic CPU_TRACE_CLOCK,
    input wire logic [4:0] PIN_IN,
    input wire logic [4:0] PIN_OUT,
    input wire logic [4:0] PIN_OE_N,
    input wire logic [4:0] GPIO_IN
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);
    // Cycles since reset; $past must not look back into reset
    logic [1:0] up_cnt_ff;
    always_ff @(posedge CLK_SYS) begin
        if (RESET) up_cnt_ff <= 2'h0;
        else if (up_cnt_ff != 2'h3) up_cnt_ff <= up_cnt_ff + 2'h1;
    end
    // Which function owns each pad
    wire logic rdy = up_cnt_ff == 2'h3;
    wire logic [3:0] en = TIMER2_CAPTURE_COMPARE_ENABLE;
    wire logic [7:0] rm = TIMER2_REMAP_OPTION;
    wire logic [15:0] pa = PORT_A_LOW_CONFIG;
    wire logic t1 = pa[3:0] == TSPM_CFG_ALT_OUT && en[0] && !rm[4];
    wire logic t3 = pa[7:4] == TSPM_CFG_ALT_OUT && en[2] && !rm[6];
    wire logic t2 = pa[15:12] == TSPM_CFG_ALT_OUT && en[1] && !rm[5];
    wire logic t4 = PORT_B_HIGH_CONFIG == TSPM_CFG_ALT_OUT && en[3] && rm[7];
    wire logic rts = PORT_B_HIGH_CONFIG == TSPM_CFG_ALT_OUT && !(en[3] && rm[7])
        && SERIAL1_MODE_SELECT == TSPM_MODE_UART && SERIAL1_UART_CONFIG[5];
    wire logic trc = pa[15:12] == TSPM_CFG_ALT_OUT && !(en[1] && !rm[5]) && TRACE_ENABLE;
    wire logic mosi = pa[3:0] == TSPM_CFG_ALT_OUT && !(en[0] && !rm[4])
        && SERIAL2_MODE_SELECT == TSPM_MODE_SPI && SERIAL2_SPI_CONFIG[4];
    wire logic sda = pa[7:4] == TSPM_CFG_ALT_OD && !(en[2] && !rm[6])
        && SERIAL2_MODE_SELECT == TSPM_MODE_TWI;
    a_ch1_on_a0: assert property (
        rdy && $past(t1) |-> !PIN_OE_N[0] && PIN_OUT[0] == $past(TIMER2_CHANNEL_OUT[0]))
        else $error("channel one missing on A0");
    a_ch3_on_a1: assert property (
        rdy && $past(t3) |-> !PIN_OE_N[1] && PIN_OUT[1] == $past(TIMER2_CHANNEL_OUT[2]))
        else $error("channel three missing on A1");
    a_ch2_on_a3: assert property (
        rdy && $past(t2) |-> !PIN_OE_N[3] && PIN_OUT[3] == $past(TIMER2_CHANNEL_OUT[1]))
        else $error("channel two missing on A3");
    a_ch4_on_b4: assert property (
        rdy && $past(t4) |-> !PIN_OE_N[4] && PIN_OUT[4] == $past(TIMER2_CHANNEL_OUT[3]))
        else $error("channel four missing on B4");
    a_rts_on_b4: assert property (
        rdy && $past(rts) |-> !PIN_OE_N[4] && PIN_OUT[4] == $past(SERIAL1_REQUEST_TO_SEND_N))
        else $error("request to send missing on B4");
    a_trace_on_a3: assert property (
        rdy && $past(trc) |-> !PIN_OE_N[3] && PIN_OUT[3] == $past(CPU_TRACE_CLOCK))
        else $error("trace clock missing on A3");
    a_mosi_on_a0: assert property (
        rdy && $past(mosi) |-> !PIN_OE_N[0] && PIN_OUT[0] == $past(SERIAL2_MASTER_OUT_TX))
        else $error("master data missing on A0");
    a_sda_open_drain: assert property (
        rdy && $past(sda) |-> PIN_OE_N[1] == $past(SERIAL2_TWOWIRE_DATA_TX)
        && (PIN_OE_N[1] || !PIN_OUT[1])) else $error("two-wire data not open-drain");
    a_gpio_in_lag: assert property (
        (rdy && $stable(PIN_IN)) [*6] |-> GPIO_IN == PIN_IN)
        else $error("pad input not seen");
    c_ch4_remap: cover property (rdy && $past(t4));
    c_rts: cover property (rdy && $past(rts));
    c_sda: cover property (rdy && $past(sda));
endmodule : tspm_mux_checker

bind tspm_mux tspm_mux_checker u_tspm_mux_checker (.*);

// ### verif/tspm_mux_tb.sv
`timescale 1ns/1ps
module tspm_mux_tb
    import tspm_pkg::*;
;
    logic CLK_SYS, RESET, TRACE_ENABLE, SERIAL1_REQUEST_TO_SEND_N, CPU_TRACE_CLOCK;
    logic SERIAL2_MASTER_OUT_TX, SERIAL2_MASTER_IN_TX, SERIAL2_SPI_CLOCK_TX;
    logic SERIAL2_TWOWIRE_DATA_TX, SERIAL2_TWOWIRE_CLOCK_TX, SERIAL1_SLAVE_SELECT_N;
    logic [7:0] TIMER2_REMAP_OPTION, SERIAL1_UART_CONFIG, SERIAL1_SPI_CONFIG, SERIAL2_SPI_CONFIG;
    logic [3:0] TIMER2_CAPTURE_COMPARE_ENABLE, PORT_B_HIGH_CONFIG, TIMER2_CHANNEL_OUT;
    logic [3:0] TIMER2_CHANNEL_IN;
    logic [15:0] PORT_A_LOW_CONFIG;
    logic [1:0] SERIAL1_MODE_SELECT, SERIAL2_MODE_SELECT;
    logic [4:0] GPIO_OUT, PIN_IN, PIN_OUT, PIN_OE_N, GPIO_IN, ext_en, ext_val;
    logic SERIAL2_MASTER_OUT_RX, SERIAL2_MASTER_IN_RX, SERIAL2_SPI_CLOCK_RX;
    logic SERIAL2_SLAVE_SELECT_N, SERIAL2_TWOWIRE_DATA_RX, SERIAL2_TWOWIRE_CLOCK_RX;
    int num_errors, num_checks;
    tspm_mux u_tspm_mux (.*);
    tspm_board u_tspm_board (.pin_out(PIN_OUT), .pin_oe_n(PIN_OE_N), .ext_en(ext_en),
        .ext_val(ext_val), .pin_in(PIN_IN));
    // 125 MHz system clock
    initial begin
        CLK_SYS = 1'b0;
        forever #4 CLK_SYS = ~CLK_SYS;
    end
    task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task close_out;
        if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    // Let edges land, then look between edges
    task settle(input int n);
        repeat (n) @(posedge CLK_SYS);
        #1;
    endtask : settle
    // All timer channels home, then two remapped away; serial waits for the timer
    task t_timer;
        @(posedge CLK_SYS);
        PORT_A_LOW_CONFIG <= 16'h9999;
        PORT_B_HIGH_CONFIG <= 4'h9;
        TIMER2_CAPTURE_COMPARE_ENABLE <= 4'hF;
        TIMER2_CHANNEL_OUT <= 4'hA;
        SERIAL2_MODE_SELECT <= TSPM_MODE_SPI;
        SERIAL2_SPI_CONFIG <= 8'h10;
        SERIAL2_MASTER_OUT_TX <= 1'b1;
        settle(2);
        chk("pin_out_a", PIN_OUT[3:0], 4'hC);
        chk("oe_n_a", PIN_OE_N[3:0], 4'h0);
        @(posedge CLK_SYS);
        TIMER2_REMAP_OPTION <= 8'h90;
        settle(2);
        chk("b4_remap", {PIN_OE_N[4], PIN_OUT[4]}, 2'h1);
        chk("a0_mosi", PIN_OUT[0], 1'h1);
    endtask : t_timer
    // Timer outputs off: serial master, trace clock and request to send take the pads
    task t_shared;
        @(posedge CLK_SYS);
        TIMER2_REMAP_OPTION <= 8'h00;
        TIMER2_CAPTURE_COMPARE_ENABLE <= 4'h0;
        SERIAL2_SPI_CLOCK_TX <= 1'b1;
        TRACE_ENABLE <= 1'b1;
        CPU_TRACE_CLOCK <= 1'b1;
        SERIAL1_MODE_SELECT <= TSPM_MODE_UART;
        SERIAL1_UART_CONFIG <= 8'h20;
        settle(2);
        chk("shared_out", {PIN_OUT[4:2], PIN_OUT[0]}, 4'h7);
        chk("shared_oe_n", PIN_OE_N, 5'h02);
        // Slave role: data out moves to A1, A0 and A2 are released
        @(posedge CLK_SYS);
        SERIAL2_SPI_CONFIG <= 8'h00;
        SERIAL2_MASTER_IN_TX <= 1'b1;
        settle(2);
        chk("miso_a1", {PIN_OE_N[2:0], PIN_OUT[1]}, 4'hB);
    endtask : t_shared
    // Two-wire pads pull low only; a released clock reads back high
    task t_twowire;
        @(posedge CLK_SYS);
        SERIAL2_MODE_SELECT <= TSPM_MODE_TWI;
        PORT_A_LOW_CONFIG <= 16'h9DD9;
        SERIAL2_TWOWIRE_CLOCK_TX <= 1'b1;
        settle(8);
        chk("tw_oe_n", PIN_OE_N[2:1], 2'h2);
        chk("tw_data", PIN_OUT[1], 1'h0);
        chk("tw_rx", {SERIAL2_TWOWIRE_CLOCK_RX, SERIAL2_TWOWIRE_DATA_RX}, 2'h2);
    endtask : t_twowire
    // Pads as inputs: plain port, capture and slave inputs, before and after remap
    task t_input;
        @(posedge CLK_SYS);
        {PORT_A_LOW_CONFIG, PORT_B_HIGH_CONFIG} <= 20'h44444;
        {SERIAL1_MODE_SELECT, SERIAL2_MODE_SELECT} <= {TSPM_MODE_SPI, TSPM_MODE_SPI};
        SERIAL2_SPI_CONFIG <= 8'h00;
        ext_en <= 5'h1F;
        ext_val <= 5'h15;
        settle(7);
        chk("gpio_in", GPIO_IN, 5'h15);
        chk("cap_home", TIMER2_CHANNEL_IN, 4'h9);
        chk("s2_slave", {SERIAL2_MASTER_OUT_RX, SERIAL2_SPI_CLOCK_RX}, 2'h3);
        chk("sel_a", {SERIAL1_SLAVE_SELECT_N, SERIAL2_SLAVE_SELECT_N}, 2'h2);
        @(posedge CLK_SYS);
        TIMER2_REMAP_OPTION <= 8'h80;
        ext_val <= 5'h0A;
        settle(7);
        chk("cap_remap", TIMER2_CHANNEL_IN, 4'h6);
        chk("sel_b", {SERIAL1_SLAVE_SELECT_N, SERIAL2_SLAVE_SELECT_N}, 2'h1);
        @(posedge CLK_SYS);
        {PORT_A_LOW_CONFIG, PORT_B_HIGH_CONFIG} <= 20'h11111;
        GPIO_OUT <= 5'h07;
        settle(2);
        chk("gpio_out", {PIN_OE_N, PIN_OUT}, 10'h007);
        // Master role samples A1; A0 input is ignored and idles low
        @(posedge CLK_SYS);
        SERIAL2_SPI_CONFIG <= 8'h10;
        settle(5);
        chk("s2_master_in", {SERIAL2_MASTER_IN_RX, SERIAL2_MASTER_OUT_RX}, 2'h2);
    endtask : t_input
    // Main sequence
    initial begin
        {TRACE_ENABLE, SERIAL1_REQUEST_TO_SEND_N, CPU_TRACE_CLOCK, SERIAL2_MASTER_OUT_TX,
            SERIAL2_MASTER_IN_TX, SERIAL2_SPI_CLOCK_TX, SERIAL2_TWOWIRE_DATA_TX,
            SERIAL2_TWOWIRE_CLOCK_TX} = 8'h00;
        {TIMER2_REMAP_OPTION, SERIAL1_UART_CONFIG, SERIAL1_SPI_CONFIG, SERIAL2_SPI_CONFIG,
            TIMER2_CAPTURE_COMPARE_ENABLE, PORT_B_HIGH_CONFIG, TIMER2_CHANNEL_OUT,
            PORT_A_LOW_CONFIG, SERIAL1_MODE_SELECT, SERIAL2_MODE_SELECT, GPIO_OUT, ext_en,
            ext_val} = 79'h0;
        RESET = 1'b1;
        settle(4);
        chk("rst_oe_n", PIN_OE_N, TSPM_OE_N_RST);
        @(posedge CLK_SYS);
        RESET <= 1'b0;
        t_timer();
        t_shared();
        t_twowire();
        t_input();
        close_out();
    end
    // Scenarios need under 100 cycles
    initial begin
        repeat (1000) @(posedge CLK_SYS);
        num_errors++;
        close_out();
    end
endmodule : tspm_mux_tb
